// ### verilog/qdsc_core.sv
// core of the quad dac serial command port: decode, channel and mode registers
// assumes pins and link signals are asynchronous to core_clk
`timescale 1ns/100ps
// Operation
// RULE_01: 32-bit frame: ignore, command, address, data
// RULE_02: 16-bit code follows address, low bits ignored
// RULE_03: commands 0-3 write input and outputs
// RULE_04: commands 4-8 modes, others reserved
// RULE_05: address 0-3 one channel, f all
// RULE_06: frame select low, sample data falling edges
// RULE_07: execute on 32nd falling edge
// RULE_08: host keeps frame select high 2 us
// RULE_09: early frame select rise discards frame
// RULE_10: chain register bit 1 enables chaining
// RULE_11: chain mode shifts out after 32 clocks
// RULE_12: chain frames must be multiples of 32
// RULE_13: frame select rise stops shift, latches
// RULE_14: host pulses load input in chain mode
// RULE_15: reset restores defaults and power-up code
// RULE_16: software reset equals power-on reset
// RULE_17: load and clear ignored during reset
// RULE_18: host writes nothing during 50 us
// RULE_19: host issues software reset after slow ramp
// RULE_20: power-down mode bits and channel mask
// RULE_21: clear code select, 11 keeps value
// RULE_22: load register forces per-channel update
// RULE_23: load input low updates on write
// RULE_24: reserved command changes nothing
module qdsc_core (
    // clock, enable and reset
    input  wire logic                 core_clk,
    input  wire logic                 clk_en,
    input  wire logic                 reset,
    // serial link
    input  wire logic                 shift_clk,
    input  wire logic                 frame_sel_n,
    input  wire logic                 serial_data_in,
    output logic                      chain_data_out,
    // control pins
    input  wire logic                 load_outputs_n,
    input  wire logic                 clear_outputs_n,
    input  wire logic                 power_up_level,
    // channel, chain mode and reset state
    output logic [3:0][15:0]          dac_code_r,
    output logic [3:0][1:0]           pd_mode_r,
    output logic                      chain_mode_enable_r,
    output logic                      por_busy_r
);

    // ************************************************************
    // link and pin crossing
    // ************************************************************
    qdsc_pkg::qdsc_frame_s link_word;
    logic                  link_tog;
    logic                  link_aligned;
    logic [2:0]            fs_sy_r;
    logic [2:0]            tog_sy_r;
    logic [1:0]            al_sy_r;
    logic [2:0]            ld_sy_r;
    logic [2:0]            cl_sy_r;
    logic [1:0]            pu_sy_r;

    qdsc_link u_link (
        .shift_clk         (shift_clk),
        .reset             (reset),
        .frame_sel_n       (frame_sel_n),
        .serial_data_in    (serial_data_in),
        .chain_data_out    (chain_data_out),
        .chain_mode_enable (chain_mode_enable_r),
        .word_r            (link_word),
        .word_tog_r        (link_tog),
        .aligned_r         (link_aligned)
    );

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fs_sy_r  <= 3'h7;
            tog_sy_r <= 3'h0;
            al_sy_r  <= 2'h0;
            ld_sy_r  <= 3'h7;
            cl_sy_r  <= 3'h7;
            pu_sy_r  <= 2'h0;
        end else if (clk_en) begin
            fs_sy_r  <= {fs_sy_r[1:0], frame_sel_n};
            tog_sy_r <= {tog_sy_r[1:0], link_tog};
            al_sy_r  <= {al_sy_r[0], link_aligned};
            ld_sy_r  <= {ld_sy_r[1:0], load_outputs_n};
            cl_sy_r  <= {cl_sy_r[1:0], clear_outputs_n};
            pu_sy_r  <= {pu_sy_r[0], power_up_level};
        end
    end

    // ************************************************************
    // frame handling
    // ************************************************************
    logic                  tog_edge;
    logic                  fs_rise;
    logic                  load_outputs_n_fall;
    logic                  load_outputs_n_low;
    logic                  clr_fall;
    logic                  pend_v_r;
    qdsc_pkg::qdsc_frame_s pend_r;
    logic                  exec_v;
    qdsc_pkg::qdsc_frame_s x_word;
    logic [3:0]            x_cmd;
    logic [3:0]            x_addr;
    logic [15:0]           x_data;

    assign tog_edge  = tog_sy_r[2] ^ tog_sy_r[1];
    assign fs_rise   = fs_sy_r[1] && !fs_sy_r[2];
    assign load_outputs_n_fall = ld_sy_r[2] && !ld_sy_r[1];
    assign load_outputs_n_low  = !ld_sy_r[1];
    assign clr_fall  = cl_sy_r[2] && !cl_sy_r[1];

    // standalone runs at once; chain waits for an aligned frame end
    assign exec_v = !por_busy_r && (chain_mode_enable_r ?
        (fs_rise && al_sy_r[1] && (pend_v_r || tog_edge)) : tog_edge); // RULE_07 RULE_12 RULE_13
    assign x_word = (chain_mode_enable_r && !tog_edge) ? pend_r : link_word;
    assign x_cmd  = x_word.command_field; // RULE_01
    assign x_addr = x_word.channel_select_field;
    assign x_data = x_word.payload[qdsc_pkg::DATA_LSB +: qdsc_pkg::DATA_W]; // RULE_02

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pend_v_r <= 1'b0;
            pend_r   <= '0;
        end else if (clk_en) begin
            if (chain_mode_enable_r && tog_edge && !fs_rise) begin
                pend_v_r <= 1'b1;
                pend_r   <= link_word;
            end else if (fs_rise) begin
                pend_v_r <= 1'b0;
            end
        end
    end

    function automatic logic ch_hit(input logic [3:0] addr, input int ch);
        ch_hit = (addr == qdsc_pkg::ADDR_ALL) || (addr == 4'(ch)); // RULE_05
    endfunction

    function automatic logic [15:0] clear_code(input logic [1:0] sel);
        case (sel)
            qdsc_pkg::CLR_SEL_MID:  clear_code = qdsc_pkg::CODE_MID;
            qdsc_pkg::CLR_SEL_FULL: clear_code = qdsc_pkg::CODE_FULL;
            default:                clear_code = qdsc_pkg::CODE_ZERO;
        endcase
    endfunction

    // ************************************************************
    // reset sequencing and configuration
    // ************************************************************
    logic [qdsc_pkg::POR_CNT_W-1:0] por_cnt_r;
    logic [15:0]                     pu_code_r;
    logic [1:0]                      clr_sel_r;
    logic [3:0]                      load_r;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            por_busy_r <= 1'b1;
            por_cnt_r  <= qdsc_pkg::POR_CNT_RESET;
            pu_code_r  <= qdsc_pkg::CODE_ZERO;
        end else if (clk_en) begin
            if (por_busy_r) begin
                pu_code_r <= pu_sy_r[1] ? qdsc_pkg::CODE_MID : qdsc_pkg::CODE_ZERO; // RULE_15
                por_cnt_r <= por_cnt_r + 10'h001;
                if (por_cnt_r == qdsc_pkg::POR_LAST) begin
                    por_busy_r <= 1'b0;
                end
            end else if (exec_v && x_cmd == qdsc_pkg::CMD_SOFT_RST) begin
                por_busy_r <= 1'b1; // RULE_16
                por_cnt_r  <= qdsc_pkg::POR_CNT_RESET;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            clr_sel_r           <= qdsc_pkg::CLR_SEL_RESET;
            load_r              <= qdsc_pkg::LOAD_RESET;
            chain_mode_enable_r <= qdsc_pkg::CHAIN_RESET;
        end else if (clk_en) begin
            if (por_busy_r) begin
                clr_sel_r           <= qdsc_pkg::CLR_SEL_RESET; // RULE_15
                load_r              <= qdsc_pkg::LOAD_RESET;
                chain_mode_enable_r <= qdsc_pkg::CHAIN_RESET;
            end else if (exec_v) begin
                case (x_cmd)
                    qdsc_pkg::CMD_CLR_CODE: clr_sel_r <= x_word.payload[1:0]; // RULE_21
                    qdsc_pkg::CMD_LOAD_REG: load_r <= x_word.payload[3:0]; // RULE_22
                    qdsc_pkg::CMD_CHAIN:
                        chain_mode_enable_r <= x_word.payload[qdsc_pkg::CHAIN_BIT]; // RULE_10
                    default: ; // RULE_24
                endcase
            end
        end
    end

    // ************************************************************
    // channel registers
    // ************************************************************
    logic [3:0][15:0] in_r;

    for (genvar ch = 0; ch < qdsc_pkg::NUM_CH; ch++) begin : g_ch
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                in_r[ch]       <= qdsc_pkg::CODE_ZERO;
                dac_code_r[ch] <= qdsc_pkg::CODE_ZERO;
                pd_mode_r[ch]  <= qdsc_pkg::PD_MODE_RESET;
            end else if (clk_en) begin
                if (por_busy_r) begin
                    in_r[ch]       <= pu_code_r; // RULE_15 RULE_17
                    dac_code_r[ch] <= pu_code_r;
                    pd_mode_r[ch]  <= qdsc_pkg::PD_MODE_RESET;
                end else if (clr_fall && clr_sel_r != qdsc_pkg::CLR_SEL_NOP) begin
                    in_r[ch]       <= clear_code(clr_sel_r); // RULE_21
                    dac_code_r[ch] <= clear_code(clr_sel_r);
                end else if (exec_v) begin
                    case (x_cmd) // RULE_03 RULE_04
                        qdsc_pkg::CMD_WR_IN: begin
                            if (ch_hit(x_addr, ch)) begin
                                in_r[ch] <= x_data;
                                if (load_outputs_n_low || load_r[ch]) begin
                                    dac_code_r[ch] <= x_data; // RULE_22 RULE_23
                                end
                            end
                        end
                        qdsc_pkg::CMD_UPD: begin
                            if (ch_hit(x_addr, ch)) begin
                                dac_code_r[ch] <= in_r[ch];
                            end
                        end
                        qdsc_pkg::CMD_WR_UPD_ALL: begin
                            if (ch_hit(x_addr, ch)) begin
                                in_r[ch]       <= x_data;
                                dac_code_r[ch] <= x_data;
                            end else begin
                                dac_code_r[ch] <= in_r[ch];
                            end
                        end
                        qdsc_pkg::CMD_WR_UPD: begin
                            if (ch_hit(x_addr, ch)) begin
                                in_r[ch]       <= x_data;
                                dac_code_r[ch] <= x_data;
                            end
                        end
                        qdsc_pkg::CMD_PWR: begin
                            if (x_word.payload[ch]) begin
                                pd_mode_r[ch] <= x_word.payload[qdsc_pkg::PD_MODE_LO +: 2]; // RULE_20
                            end
                        end
                        default: ; // RULE_24
                    endcase
                end else if (load_outputs_n_fall) begin
                    dac_code_r[ch] <= in_r[ch]; // RULE_23
                end
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    logic quiet;
    assign quiet = clk_en && !por_busy_r && !clr_fall;

    a_write_input: assert property (@(posedge core_clk) disable iff (reset)
        (quiet && exec_v && x_cmd == 4'h0 && ch_hit(x_addr, 0))
        |=> in_r[0] == $past(x_data)) // RULE_03
        else $error("input register not written");
    a_sync_update: assert property (@(posedge core_clk) disable iff (reset)
        (quiet && exec_v && x_cmd == 4'h0 && ch_hit(x_addr, 3) && load_outputs_n_low)
        |=> dac_code_r[3] == $past(x_data)) // RULE_23
        else $error("outputs not updated with load input low");
    a_chain_write: assert property (@(posedge core_clk) disable iff (reset)
        (quiet && exec_v && x_cmd == 4'h8)
        |=> chain_mode_enable_r == $past(x_word.payload[1])) // RULE_10
        else $error("chain mode bit not written");
    a_reserved_keep: assert property (@(posedge core_clk) disable iff (reset)
        (quiet && exec_v && x_cmd > 4'h8 && !load_outputs_n_fall)
        |=> $stable(in_r) && $stable(dac_code_r) && $stable(chain_mode_enable_r)
            && $stable(pd_mode_r) && $stable(load_r)) // RULE_24
        else $error("reserved command changed state");
    a_por_length: assert property (@(posedge core_clk) disable iff (reset)
        $fell(por_busy_r) |-> $past(por_cnt_r) == qdsc_pkg::POR_LAST) // RULE_16
        else $error("reset interval length wrong");
    a_por_ignore: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && por_busy_r && (load_outputs_n_fall || clr_fall))
        |=> dac_code_r[1] == $past(pu_code_r)) // RULE_17
        else $error("pin event acted during reset");
    a_clear_mid: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && !por_busy_r && clr_fall && clr_sel_r == 2'h1)
        |=> dac_code_r[0] == 16'h8000 && in_r[3] == 16'h8000) // RULE_21
        else $error("clear did not load midscale");
    a_chain_unaligned: assert property (@(posedge core_clk) disable iff (reset)
        (quiet && chain_mode_enable_r && fs_rise && !al_sy_r[1] && !load_outputs_n_fall)
        |=> $stable(in_r) && $stable(dac_code_r)) // RULE_12
        else $error("unaligned chain frame executed");
    a_power_mode: assert property (@(posedge core_clk) disable iff (reset)
        (quiet && exec_v && x_cmd == 4'h4 && x_word.payload[0])
        |=> pd_mode_r[0] == $past(x_word.payload[9:8])) // RULE_20
        else $error("power mode not applied");
    a_load_reg: assert property (@(posedge core_clk) disable iff (reset)
        (quiet && exec_v && x_cmd == 4'h6) |=> load_r == $past(x_word.payload[3:0])) // RULE_22
        else $error("load register not written");

    c_standalone: cover property (@(posedge core_clk) disable iff (reset)
        exec_v && !chain_mode_enable_r);
    c_chain_exec: cover property (@(posedge core_clk) disable iff (reset)
        exec_v && chain_mode_enable_r);
    c_soft_reset: cover property (@(posedge core_clk) disable iff (reset)
        exec_v && x_cmd == 4'h7);

endmodule

// ### verilog/qdsc_pkg.sv
// package of constants and types for the quad dac serial command port
// assumes a 20 MHz core clock and a 16-bit code word
package qdsc_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int POR_TIME_NS   = 50000;
    localparam int POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_CNT_W     = 10;
    localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);
    localparam logic [POR_CNT_W-1:0] POR_CNT_RESET = 10'h000;

    // ************************************************************
    // frame layout
    // ************************************************************
    localparam int FRAME_BITS = 32;
    localparam int CNT_W      = 5;
    localparam logic [CNT_W-1:0] CNT_LAST  = 5'h1f;
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
    localparam int NUM_CH     = 4;
    localparam int DATA_W     = 16;
    localparam int DATA_LSB   = 4;
    localparam int PD_MODE_LO = 8;
    localparam int CHAIN_BIT  = 1;
    localparam logic [3:0] ADDR_ALL = 4'hf;

    // ************************************************************
    // codes and reset values
    // ************************************************************
    localparam logic [DATA_W-1:0] CODE_ZERO = 16'h0000;
    localparam logic [DATA_W-1:0] CODE_MID  = 16'h8000;
    localparam logic [DATA_W-1:0] CODE_FULL = 16'hffff;
    localparam logic [1:0] CLR_SEL_ZERO  = 2'h0;
    localparam logic [1:0] CLR_SEL_MID   = 2'h1;
    localparam logic [1:0] CLR_SEL_FULL  = 2'h2;
    localparam logic [1:0] CLR_SEL_NOP   = 2'h3;
    localparam logic [1:0] CLR_SEL_RESET = 2'h0;
    localparam logic [1:0] PD_MODE_RESET = 2'h0;
    localparam logic [3:0] LOAD_RESET    = 4'h0;
    localparam logic       CHAIN_RESET   = 1'b0;

    typedef enum logic [3:0] {
        CMD_WR_IN      = 4'h0,
        CMD_UPD        = 4'h1,
        CMD_WR_UPD_ALL = 4'h2,
        CMD_WR_UPD     = 4'h3,
        CMD_PWR        = 4'h4,
        CMD_CLR_CODE   = 4'h5,
        CMD_LOAD_REG   = 4'h6,
        CMD_SOFT_RST   = 4'h7,
        CMD_CHAIN      = 4'h8
    } qdsc_cmd_e;

    typedef struct packed {
        logic [3:0]  ignored;
        logic [3:0]  command_field;
        logic [3:0]  channel_select_field;
        logic [19:0] payload;
    } qdsc_frame_s;

endpackage

// ### verilog/qdsc_link.sv
// link-side shifter of the quad dac serial command port, on the shift clock
// assumes the shift clock may stop outside frames; frame select high clears it
`timescale 1ns/100ps
module qdsc_link (
    // clock and reset
    input  wire logic                 shift_clk,
    input  wire logic                 reset,
    // serial pins
    input  wire logic                 frame_sel_n,
    input  wire logic                 serial_data_in,
    output logic                      chain_data_out,
    // towards the core domain
    input  wire logic                 chain_mode_enable,
    output qdsc_pkg::qdsc_frame_s     word_r,
    output logic                      word_tog_r,
    output logic                      aligned_r
);

    // ************************************************************
    // shifting
    // ************************************************************
    logic                             link_clr;
    logic [qdsc_pkg::FRAME_BITS-1:0] shift_r;
    logic [qdsc_pkg::CNT_W-1:0]      cnt_r;
    logic                             past32_r;
    logic [1:0]                       chain_sync_r;
    logic [qdsc_pkg::FRAME_BITS-1:0] shift_nxt;

    assign link_clr  = reset | frame_sel_n;
    assign shift_nxt = {shift_r[qdsc_pkg::FRAME_BITS-2:0], serial_data_in};

    always_ff @(negedge shift_clk or posedge reset) begin
        if (reset) begin
            chain_sync_r <= 2'h0;
        end else begin
            chain_sync_r <= {chain_sync_r[0], chain_mode_enable};
        end
    end

    // frame select high stops shifting and drops a partial count
    always_ff @(negedge shift_clk or posedge link_clr) begin
        if (link_clr) begin
            cnt_r    <= qdsc_pkg::CNT_RESET; // RULE_09 RULE_13
            past32_r <= 1'b0;
            shift_r  <= 32'h00000000;
        end else begin
            shift_r <= shift_nxt; // RULE_06 RULE_01
            cnt_r   <= cnt_r + 5'h01;
            if (cnt_r == qdsc_pkg::CNT_LAST) begin
                past32_r <= 1'b1;
            end
        end
    end

    // ************************************************************
    // capture towards the core
    // ************************************************************
    always_ff @(negedge shift_clk or posedge reset) begin
        if (reset) begin
            word_r     <= '0;
            word_tog_r <= 1'b0;
            aligned_r  <= 1'b0;
        end else if (!frame_sel_n) begin
            aligned_r <= (cnt_r == qdsc_pkg::CNT_LAST); // RULE_12
            if (cnt_r == qdsc_pkg::CNT_LAST && (!past32_r || chain_sync_r[1])) begin
                word_r     <= shift_nxt; // RULE_07
                word_tog_r <= ~word_tog_r;
            end
        end
    end

    // chain output changes on rising edges
    always_ff @(posedge shift_clk or posedge reset) begin
        if (reset) begin
            chain_data_out <= 1'b0;
        end else begin
            chain_data_out <= chain_sync_r[1] && past32_r && shift_r[31]; // RULE_11
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_word_capture: assert property (@(negedge shift_clk) disable iff (link_clr)
        (cnt_r == qdsc_pkg::CNT_LAST && !past32_r) |=> word_r == $past(shift_nxt)) // RULE_07
        else $error("first full word not captured");
    a_chain_gate: assert property (@(posedge shift_clk) disable iff (reset)
        (!chain_sync_r[1] || !past32_r) |=> !chain_data_out) // RULE_11
        else $error("chain output active too early");

endmodule

// ### verification/qdsc_host_model.sv
// host serial master model driving frames into the command port
// assumes an 80 ns shift clock that stands still low outside frames
`timescale 1ns/100ps
module qdsc_host_model (
    // serial pins
    output logic shift_clk,
    output logic frame_sel_n,
    output logic serial_data_in
);
    initial begin
        shift_clk = 1'b0;
        frame_sel_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // ********************************
    // one frame of n bits, msb first
    // ********************************
    task automatic send(input logic [63:0] w, input int n);
        #13 frame_sel_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            #40 shift_clk = 1'b1;
            serial_data_in = w[i];
            #40 shift_clk = 1'b0;
        end
        #40 frame_sel_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #2000;
    endtask
endmodule

// ### verification/quad_dac_serial_command_port_tb_top.sv
// self-checking bench of the quad dac serial command port
// assumes qdsc_core holds the link shifter and the host model drives the serial pins
`timescale 1ns/100ps
module quad_dac_serial_command_port_tb_top;
    logic             core_clk = 1'b0;
    logic             reset = 1'b1;
    logic             clk_en = 1'b1;
    logic             load_outputs_n = 1'b1;
    logic             clear_outputs_n = 1'b1;
    logic             power_up_level = 1'b1;
    logic             shift_clk, frame_sel_n, serial_data_in, chain_data_out;
    logic [3:0][15:0] dac_code_r;
    logic [3:0][1:0]  pd_mode_r;
    logic             chain_mode_enable_r, por_busy_r;
    logic [15:0]      exp_code [4];
    logic [31:0]      shout, w1;
    logic [15:0]      d;
    logic [3:0]       ch;
    int               n_mismatch = 0, checked = 0, nclk = 0;
    always #25 core_clk = ~core_clk;
    qdsc_host_model i_qdsc_host_model (.shift_clk, .frame_sel_n, .serial_data_in);
    qdsc_core i_qdsc_core (.core_clk, .clk_en, .reset, .shift_clk, .frame_sel_n,
        .serial_data_in, .chain_data_out, .load_outputs_n, .clear_outputs_n,
        .power_up_level, .dac_code_r, .pd_mode_r, .chain_mode_enable_r, .por_busy_r);
    // ********************************
    // chain output capture past bit 32
    // ********************************
    always @(negedge shift_clk or posedge frame_sel_n) begin
        if (frame_sel_n) nclk <= 0;
        else begin
            nclk <= nclk + 1;
            if (nclk >= 32) shout <= {shout[30:0], chain_data_out};
        end
    end
    // ********************************
    // helpers
    // ********************************
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [31:0] word(input logic [3:0] c, a, input logic [19:0] p);
        return {4'($urandom), c, a, p};
    endfunction
    task automatic cmd(input logic [3:0] c, a, input logic [19:0] p);
        i_qdsc_host_model.send({32'h0, word(c, a, p)}, 32);
    endtask
    task automatic chk_all(input string nm);
        for (int i = 0; i < 4; i++) chk(nm, dac_code_r[i], exp_code[i]);
    endtask
    task automatic set_all(input logic [15:0] v);
        for (int i = 0; i < 4; i++) exp_code[i] = v;
    endtask
    task automatic wait_por;
        for (int k = 0; por_busy_r !== 1'b0; k++) begin
            @(posedge core_clk);
            if (k > 1200) begin
                n_mismatch++;
                report_and_stop();
            end
        end
    endtask
    task automatic pulse(input bit clr);
        @(posedge core_clk);
        if (clr) clear_outputs_n <= 1'b0;
        else load_outputs_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        clear_outputs_n <= 1'b1;
        load_outputs_n <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial begin
        void'($urandom(18));
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        wait_por();
        set_all(16'h8000);
        chk_all("power-up code");
        repeat (6) begin
            ch = 4'($urandom_range(3));
            d = 16'($urandom);
            cmd(4'h3, ch, {d, 4'($urandom)});
            exp_code[ch[1:0]] = d;
            chk_all("write and update");
        end
        d = 16'($urandom);
        cmd(4'h3, 4'hf, {d, 4'h0});
        set_all(d);
        cmd(4'h3, 4'h5, {~d, 4'h0});
        w1 = word(4'h3, 4'h0, {~d, 4'h0});
        i_qdsc_host_model.send({44'h0, w1[31:12]}, 20);
        for (int c = 9; c < 16; c++) cmd(4'(c), 4'h0, {~d, 4'h0});
        chk_all("all, unused address, abort, reserved");
        cmd(4'h0, 4'h1, 20'h12340);
        chk_all("input only");
        cmd(4'h1, 4'h1, 20'h0);
        exp_code[1] = 16'h1234;
        cmd(4'h0, 4'h2, 20'h56780);
        pulse(1'b0);
        exp_code[2] = 16'h5678;
        @(posedge core_clk) load_outputs_n <= 1'b0;
        cmd(4'h0, 4'h3, 20'h9abc0);
        @(posedge core_clk) load_outputs_n <= 1'b1;
        exp_code[3] = 16'h9abc;
        cmd(4'h2, 4'h0, 20'hdef00);
        exp_code[0] = 16'hdef0;
        chk_all("update, load pin, update all");
        cmd(4'h6, 4'h0, 20'h2);
        cmd(4'h0, 4'h1, 20'h4c1d0);
        exp_code[1] = 16'h4c1d;
        chk_all("load register");
        cmd(4'h6, 4'h0, 20'h0);
        for (int m = 1; m < 4; m++) begin
            ch = 4'($urandom);
            cmd(4'h4, 4'h0, {10'h0, 2'(m), 4'h0, ch});
            for (int i = 0; i < 4; i++)
                if (ch[i]) chk("power-down mode", 16'(pd_mode_r[i]), 16'(m));
        end
        for (int s = 0; s < 4; s++) begin
            cmd(4'h5, 4'h0, 20'(s));
            pulse(1'b1);
            if (s < 3) set_all(s == 0 ? 16'h0000 : s == 1 ? 16'h8000 : 16'hffff);
            chk_all("clear code");
        end
        cmd(4'h8, 4'h0, 20'h3);
        chk("chain enable", 16'(chain_mode_enable_r), 16'h1);
        w1 = 32'($urandom);
        i_qdsc_host_model.send({w1, word(4'h3, 4'h0, 20'h77770)}, 64);
        exp_code[0] = 16'h7777;
        chk("chain out", shout[31:16], w1[31:16]);
        chk("chain out", shout[15:0], w1[15:0]);
        i_qdsc_host_model.send({24'h0, 8'($urandom), word(4'h3, 4'h1, 20'h0)}, 40);
        chk_all("chain word and unaligned");
        @(posedge core_clk) power_up_level <= 1'b0;
        cmd(4'h7, 4'h0, 20'h0);
        pulse(1'b1);
        wait_por();
        set_all(16'h0000);
        chk_all("software reset");
        chk("chain after reset", 16'(chain_mode_enable_r), 16'h0);
        report_and_stop();
    end
endmodule
